// ### hw/scrb_defines.svh
// Register offsets, field positions and reset values of the system control bank.
// Included by the bank module; definitions only.
`ifndef SCRB_DEFINES_SVH
`define SCRB_DEFINES_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define SCRB_OFS_ADDR_LOW 8'h10
`define SCRB_OFS_ADDR_MID 8'h12
`define SCRB_OFS_ADDR_HIGH 8'h14
`define SCRB_OFS_BUS_CTRL 8'h20
`define SCRB_OFS_ROM_CTRL 8'h22
`define SCRB_OFS_SELFTEST 8'h24
`define SCRB_OFS_SOFT_RST 8'h26

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SCRB_BUS_DRIVE_BIT 6
`define SCRB_BUS_CLKSEL_BIT 2
`define SCRB_ROM_SWEN_BIT 4
`define SCRB_ROM_DIN_BIT 3
`define SCRB_ROM_DOUT_BIT 2
`define SCRB_ROM_SCLK_BIT 1
`define SCRB_ROM_CS_BIT 0
`define SCRB_ST_TX_DONE_BIT 12
`define SCRB_ST_TX_FAIL_BIT 11
`define SCRB_ST_TX_CNT_LSB 8
`define SCRB_ST_RX_DONE_BIT 4
`define SCRB_ST_RX_FAIL_BIT 3
`define SCRB_ST_RX_CNT_LSB 0
`define SCRB_RST_QUEUE_BIT 1
`define SCRB_RST_GLOBAL_BIT 0

// ----------------------------------------
// Reset values and ROM fetch constants
// ----------------------------------------
`define SCRB_RST_WORD 16'h0000
`define SCRB_RST_DIV 2'h0
`define SCRB_ROM_FIRST_WORD 8'h01
`define SCRB_ROM_WORDS 2'h3
`define SCRB_ROM_READ_OP 3'h6
`define SCRB_ROM_HALF_PERIOD 8'h32

`endif

// ### hw/scrb_pkg.sv
// Types shared by the system control bank.
// Assumes the defines header is on the include path.
package scrb_pkg;
  // Serial ROM address fetch states
  typedef enum logic [2:0] {
    FETCH_IDLE,
    FETCH_SELECT,
    FETCH_SHIFT,
    FETCH_STORE,
    FETCH_DONE
  } scrb_fetch_t;
endpackage

// ### hw/scrb_bank.sv
// System control register bank: station address, bus control, serial ROM
// pins, memory self-test report and soft resets.
// Assumes a synchronous host bus on clk_sys and a 3-wire serial ROM.
`timescale 1ns/1ps
`include "scrb_defines.svh"

// Behaviour
// - Fetch station address from ROM word one
// - ROM words 1,2,3 load low, middle, high
// - Address register writes never reach ROM
// - Address words at 0x10, 0x12, 0x14
// - Bus control bit 6 selects drive strength
// - Bus control bit 2 selects clock source
// - Bus control bits 1:0 set divider
// - ROM control bit 4 enables bit-bang
// - ROM control bit 3 reads data-in live
// - ROM bits 2..0 drive data, clock, select
// - Self-test both buffers after reset
// - Transmit result at bits 12, 11, 10:8
// - Receive result at bits 4, 3, 2:0
// - Bit 1 holds queue manager in reset
// - Bit 0 resets whole chip and registers
module scrb_bank #(
  parameter int ADDR_W = 8,
  parameter int CNT_W = 3
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Host register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // Serial ROM pins and strap
  input wire logic rom_present_strap,
  input wire logic rom_serial_data_in_pin,
  output logic rom_serial_data_out_pin,
  output logic rom_serial_clock_pin,
  output logic rom_chip_select_pin,
  // Memory self-test results from the buffer testers
  input wire logic tx_selftest_done,
  input wire logic tx_selftest_failed,
  input wire logic [CNT_W-1:0] tx_selftest_fail_count,
  input wire logic rx_selftest_done,
  input wire logic rx_selftest_failed,
  input wire logic [CNT_W-1:0] rx_selftest_fail_count,
  // Controls to the rest of the chip
  output logic selftest_start,
  output logic queue_manager_reset,
  output logic chip_soft_reset,
  output logic [47:0] station_address,
  output logic drive_strength_high,
  output logic bus_clock_select,
  output logic [1:0] bus_clock_divider,
  output logic rom_fetch_busy
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [15:0] addr_low_r; // Station address words
  logic [15:0] addr_mid_r;
  logic [15:0] addr_high_r;
  logic drive_r; // Bus control fields
  logic clksel_r;
  logic [1:0] div_r;
  logic sw_en_r; // ROM bit-bang fields
  logic [2:0] pins_r;
  logic qrst_r; // Soft reset bits
  logic grst_r;
  logic any_rst; // Hard or global soft reset
  logic strap_r; // Strap caught after reset
  logic strap_seen_r;
  scrb_pkg::scrb_fetch_t state_r; // ROM fetch engine
  logic [7:0] tick_r;
  logic sclk_r;
  logic cs_r;
  logic dout_r;
  logic [4:0] bit_r;
  logic [26:0] shift_r;
  logic [1:0] word_r;
  logic [15:0] rdata_nxt;
  logic tick_end;
  logic st_pulse_r;

  assign any_rst = rst | grst_r;
  assign tick_end = (tick_r == `SCRB_ROM_HALF_PERIOD);

  // ----------------------------------------
  // Strap capture
  // ----------------------------------------
  // Strap sampled once on the first clock after reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      strap_r <= 1'b0;
      strap_seen_r <= 1'b0;
    end else if (!strap_seen_r) begin
      strap_r <= rom_present_strap;
      strap_seen_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // Serial ROM address fetch
  // ----------------------------------------
  // Half-period timer for the serial clock
  always_ff @(posedge clk_sys) begin
    if (any_rst || state_r == scrb_pkg::FETCH_IDLE || tick_end) begin
      tick_r <= 8'h00;
    end else begin
      tick_r <= tick_r + 8'h01;
    end
  end

  // fetch from word one
  // Read op, 6-bit address, dummy bit, 16 data bits: 25 clocks per word
  always_ff @(posedge clk_sys) begin
    if (any_rst) begin
      state_r <= scrb_pkg::FETCH_IDLE;
      sclk_r <= 1'b0;
      cs_r <= 1'b0;
      dout_r <= 1'b0;
      bit_r <= 5'h00;
      shift_r <= 27'h000_0000;
      word_r <= 2'h0;
    end else begin
      unique case (state_r)
        scrb_pkg::FETCH_IDLE: begin
          // Start once the strap says a ROM is fitted
          if (strap_seen_r && strap_r && word_r == 2'h0) begin
            state_r <= scrb_pkg::FETCH_SELECT;
          end
        end
        scrb_pkg::FETCH_SELECT: begin
          // Load command for the current word
          cs_r <= 1'b1;
          sclk_r <= 1'b0;
          bit_r <= 5'h00;
          shift_r <= {`SCRB_ROM_READ_OP, 6'(`SCRB_ROM_FIRST_WORD + {6'h00, word_r}),
                      18'h0_0000};
          dout_r <= 1'b1;
          state_r <= scrb_pkg::FETCH_SHIFT;
        end
        scrb_pkg::FETCH_SHIFT: begin
          if (tick_end) begin
            sclk_r <= ~sclk_r;
            if (sclk_r) begin
              // Falling edge: present next command bit
              dout_r <= shift_r[25];
              shift_r <= {shift_r[25:0], rom_serial_data_in_pin};
              bit_r <= bit_r + 5'h01;
              if (bit_r == 5'd24) begin
                state_r <= scrb_pkg::FETCH_STORE;
              end
            end
          end
        end
        scrb_pkg::FETCH_STORE: begin
          cs_r <= 1'b0;
          dout_r <= 1'b0;
          word_r <= word_r + 2'h1;
          state_r <= (word_r == `SCRB_ROM_WORDS - 2'h1) ? scrb_pkg::FETCH_DONE
                                                       : scrb_pkg::FETCH_SELECT;
        end
        default: begin
          // Done until the next reset
          state_r <= scrb_pkg::FETCH_DONE;
        end
      endcase
    end
  end

  assign rom_fetch_busy = (state_r != scrb_pkg::FETCH_IDLE) &&
                          (state_r != scrb_pkg::FETCH_DONE);

  // ----------------------------------------
  // Station address registers
  // ----------------------------------------
  // word-to-register mapping
  // writes stay in the registers only
  always_ff @(posedge clk_sys) begin
    if (any_rst) begin
      addr_low_r <= `SCRB_RST_WORD;
      addr_mid_r <= `SCRB_RST_WORD;
      addr_high_r <= `SCRB_RST_WORD;
    end else if (state_r == scrb_pkg::FETCH_STORE) begin
      // Fetched data sits in the low 16 bits of the shifter
      unique case (word_r)
        2'h0: addr_low_r <= shift_r[15:0];
        2'h1: addr_mid_r <= shift_r[15:0];
        default: addr_high_r <= shift_r[15:0];
      endcase
    end else if (reg_wr) begin
      if (reg_addr == `SCRB_OFS_ADDR_LOW) addr_low_r <= reg_wdata;
      if (reg_addr == `SCRB_OFS_ADDR_MID) addr_mid_r <= reg_wdata;
      if (reg_addr == `SCRB_OFS_ADDR_HIGH) addr_high_r <= reg_wdata;
    end
  end

  assign station_address = {addr_high_r, addr_mid_r, addr_low_r};

  // ----------------------------------------
  // Bus control and ROM pin control
  // ----------------------------------------
  // drive, clock select, divider
  always_ff @(posedge clk_sys) begin
    if (any_rst) begin
      drive_r <= 1'b0;
      clksel_r <= 1'b0;
      div_r <= `SCRB_RST_DIV;
    end else if (reg_wr && reg_addr == `SCRB_OFS_BUS_CTRL) begin
      drive_r <= reg_wdata[`SCRB_BUS_DRIVE_BIT];
      clksel_r <= reg_wdata[`SCRB_BUS_CLKSEL_BIT];
      div_r <= reg_wdata[1:0];
    end
  end

  assign drive_strength_high = drive_r;
  assign bus_clock_select = clksel_r;
  assign bus_clock_divider = div_r;

  // software access enable and pin bits
  always_ff @(posedge clk_sys) begin
    if (any_rst) begin
      sw_en_r <= 1'b0;
      pins_r <= 3'h0;
    end else if (reg_wr && reg_addr == `SCRB_OFS_ROM_CTRL) begin
      sw_en_r <= reg_wdata[`SCRB_ROM_SWEN_BIT];
      pins_r <= reg_wdata[2:0];
    end
  end

  // bits drive the pins under software access
  always_comb begin
    if (sw_en_r) begin
      rom_serial_data_out_pin = pins_r[`SCRB_ROM_DOUT_BIT];
      rom_serial_clock_pin = pins_r[`SCRB_ROM_SCLK_BIT];
      rom_chip_select_pin = pins_r[`SCRB_ROM_CS_BIT];
    end else begin
      rom_serial_data_out_pin = dout_r;
      rom_serial_clock_pin = sclk_r;
      rom_chip_select_pin = cs_r;
    end
  end

  // ----------------------------------------
  // Soft resets and self-test start
  // ----------------------------------------
  // queue reset, global reset, held while set
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      qrst_r <= 1'b0;
      grst_r <= 1'b0;
    end else if (reg_wr && reg_addr == `SCRB_OFS_SOFT_RST) begin
      qrst_r <= reg_wdata[`SCRB_RST_QUEUE_BIT];
      grst_r <= reg_wdata[`SCRB_RST_GLOBAL_BIT];
    end else if (grst_r) begin
      // Global reset also returns the queue bit to default
      qrst_r <= 1'b0;
    end
  end

  assign queue_manager_reset = qrst_r | grst_r;
  assign chip_soft_reset = grst_r;

  // start self-test on the cycle after reset ends
  always_ff @(posedge clk_sys) begin
    if (any_rst) begin
      st_pulse_r <= 1'b1;
    end else begin
      st_pulse_r <= 1'b0;
    end
  end

  assign selftest_start = st_pulse_r & ~any_rst;

  // ----------------------------------------
  // Register read path
  // ----------------------------------------
  // Read mux; unmapped offsets read zero
  always_comb begin
    rdata_nxt = 16'h0000;
    unique case (reg_addr)
      `SCRB_OFS_ADDR_LOW: rdata_nxt = addr_low_r;
      `SCRB_OFS_ADDR_MID: rdata_nxt = addr_mid_r;
      `SCRB_OFS_ADDR_HIGH: rdata_nxt = addr_high_r;
      `SCRB_OFS_BUS_CTRL: begin
        rdata_nxt[`SCRB_BUS_DRIVE_BIT] = drive_r;
        rdata_nxt[`SCRB_BUS_CLKSEL_BIT] = clksel_r;
        rdata_nxt[1:0] = div_r;
      end
      `SCRB_OFS_ROM_CTRL: begin
        rdata_nxt[`SCRB_ROM_SWEN_BIT] = sw_en_r;
        rdata_nxt[`SCRB_ROM_DIN_BIT] = rom_serial_data_in_pin;
        rdata_nxt[2:0] = pins_r;
      end
      `SCRB_OFS_SELFTEST: begin
        rdata_nxt[`SCRB_ST_TX_DONE_BIT] = tx_selftest_done;
        rdata_nxt[`SCRB_ST_TX_FAIL_BIT] = tx_selftest_failed;
        rdata_nxt[`SCRB_ST_TX_CNT_LSB +: CNT_W] = tx_selftest_fail_count;
        rdata_nxt[`SCRB_ST_RX_DONE_BIT] = rx_selftest_done;
        rdata_nxt[`SCRB_ST_RX_FAIL_BIT] = rx_selftest_failed;
        rdata_nxt[`SCRB_ST_RX_CNT_LSB +: CNT_W] = rx_selftest_fail_count;
      end
      `SCRB_OFS_SOFT_RST: begin
        rdata_nxt[`SCRB_RST_QUEUE_BIT] = qrst_r;
        rdata_nxt[`SCRB_RST_GLOBAL_BIT] = grst_r;
      end
      default: rdata_nxt = 16'h0000;
    endcase
  end

  // Registered read data, one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_addr_low_write: assert property (
    @(posedge clk_sys) disable iff (any_rst)
    (reg_wr && reg_addr == `SCRB_OFS_ADDR_LOW && state_r != scrb_pkg::FETCH_STORE)
      |=> addr_low_r == $past(reg_wdata))
    else $error("low address word not written");

  a_drive_strength: assert property (
    @(posedge clk_sys) disable iff (any_rst)
    (reg_wr && reg_addr == `SCRB_OFS_BUS_CTRL)
      |=> drive_strength_high == $past(reg_wdata[6]))
    else $error("drive strength bit wrong");

  a_clk_select: assert property (
    @(posedge clk_sys) disable iff (any_rst)
    (reg_wr && reg_addr == `SCRB_OFS_BUS_CTRL)
      |=> bus_clock_select == $past(reg_wdata[2]))
    else $error("clock select bit wrong");

  a_clk_divider: assert property (
    @(posedge clk_sys) $fell(any_rst) |-> bus_clock_divider == 2'h0)
    else $error("divider not default after reset");

  a_rom_sw_drive: assert property (
    @(posedge clk_sys) disable iff (rst)
    sw_en_r |-> rom_chip_select_pin == pins_r[0] && rom_serial_clock_pin == pins_r[1]
      && rom_serial_data_out_pin == pins_r[2])
    else $error("software pin control not applied");

  a_rom_din_live: assert property (
    @(posedge clk_sys) disable iff (rst)
    (reg_rd && reg_addr == `SCRB_OFS_ROM_CTRL)
      |=> reg_rdata[3] == $past(rom_serial_data_in_pin))
    else $error("data-in status not live");

  a_selftest_rx: assert property (
    @(posedge clk_sys) disable iff (rst)
    (reg_rd && reg_addr == `SCRB_OFS_SELFTEST)
      |=> reg_rdata[4:0] == {$past(rx_selftest_done), $past(rx_selftest_failed),
                             $past(rx_selftest_fail_count)})
    else $error("receive self-test fields wrong");

  a_queue_reset: assert property (
    @(posedge clk_sys) disable iff (rst)
    (reg_wr && reg_addr == `SCRB_OFS_SOFT_RST && reg_wdata[1]) |=> queue_manager_reset)
    else $error("queue manager reset not held");

  a_global_reset: assert property (
    @(posedge clk_sys) disable iff (rst)
    grst_r |=> addr_low_r == 16'h0000 && drive_r == 1'b0 && sw_en_r == 1'b0)
    else $error("global reset did not clear registers");

  a_reserved_zero: assert property (
    @(posedge clk_sys) disable iff (rst)
    (reg_rd && reg_addr == 8'h16) |=> reg_rdata == 16'h0000)
    else $error("reserved offset read not zero");

  a_fetch_start: assert property (
    @(posedge clk_sys) disable iff (any_rst)
    (state_r == scrb_pkg::FETCH_IDLE && strap_seen_r && strap_r && word_r == 2'h0)
      |=> state_r == scrb_pkg::FETCH_SELECT)
    else $error("address fetch did not start");

endmodule

// ### tb/scrb_rom_model.sv
// Behavioural serial ROM standing on the far side of the fetch pins.
// Assumes a 3-bit opcode, 6-bit word address, a dummy zero, then 16 data bits MSB first.
`timescale 1ns/1ps

module scrb_rom_model #(
  parameter logic [15:0] WORD1 = 16'h1a2b,
  parameter logic [15:0] WORD2 = 16'h3c4d,
  parameter logic [15:0] WORD3 = 16'h5e6f,
  parameter int RESP_NS = 0
) (
  // Pins from the device
  input wire logic rom_cs,
  input wire logic rom_sk,
  input wire logic rom_di,
  // Pins and status to the bench
  output logic rom_do,
  output logic [7:0] write_count
);
  // -------------------------------
  // Command capture and data shift
  // -------------------------------
  logic [8:0] cmd_r; // Opcode and address bits
  logic [15:0] word_r; // Word being shifted out
  int bit_cnt; // Rising clocks since select, stops at 9
  initial begin
    rom_do = 1'b1;
    write_count = 8'h00;
    bit_cnt = 0;
  end
  // Shift on rising clock while selected
  always @(posedge rom_sk) begin
    if (rom_cs && bit_cnt < 9) begin
      cmd_r = {cmd_r[7:0], rom_di};
      bit_cnt = bit_cnt + 1;
      if (bit_cnt == 9) begin
        word_r = (cmd_r[5:0] == 6'h01) ? WORD1 : (cmd_r[5:0] == 6'h02) ? WORD2 : WORD3;
        if (cmd_r[8:6] != 3'h6) write_count = write_count + 8'h01;
        // Dummy zero after the last address bit
        rom_do <= #(RESP_NS) 1'b0;
      end
    end else if (rom_cs) begin
      rom_do <= #(RESP_NS) word_r[15];
      word_r = {word_r[14:0], 1'b0};
    end
  end
  // Released line shows the inverse of its last level
  always @(negedge rom_cs) begin
    bit_cnt = 0;
    rom_do <= ~rom_do;
  end
endmodule

// ### tb/system_control_register_bank_bench.sv
// Self-checking bench for the system control register bank.
// Assumes the bank, its package and the serial ROM model are compiled first.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin err_count++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end

module system_control_register_bank_bench;
  // -------------------------------
  // Signals
  // -------------------------------
  localparam logic [15:0] W1 = 16'h1a2b; // ROM word one
  localparam logic [15:0] W2 = 16'h3c4d; // ROM word two
  localparam logic [15:0] W3 = 16'h5e6f; // ROM word three
  logic clk_sys, rst, reg_wr, reg_rd, din_tb, sw_mode, rom_do, din, dout, sclk, cs;
  logic busy, st_start, qm_rst, chip_rst, drv_hi, clk_sel, txd, txf, rxd, rxf, strap;
  logic [7:0] reg_addr, wr_cnt;
  logic [15:0] reg_wdata, reg_rdata, rd_v, v;
  logic [2:0] txc, rxc;
  logic [1:0] div;
  logic [47:0] sta;
  int err_count, tests_run, pulses, seed_v, i;
  // Data-in pin: bench drives it during bit-bang
  assign din = sw_mode ? din_tb : rom_do;

  scrb_bank i_scrb_bank (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rom_present_strap(strap),
    .rom_serial_data_in_pin(din), .rom_serial_data_out_pin(dout), .rom_serial_clock_pin(sclk),
    .rom_chip_select_pin(cs), .tx_selftest_done(txd), .tx_selftest_failed(txf),
    .tx_selftest_fail_count(txc), .rx_selftest_done(rxd), .rx_selftest_failed(rxf),
    .rx_selftest_fail_count(rxc), .selftest_start(st_start), .queue_manager_reset(qm_rst),
    .chip_soft_reset(chip_rst), .station_address(sta), .drive_strength_high(drv_hi),
    .bus_clock_select(clk_sel), .bus_clock_divider(div), .rom_fetch_busy(busy));
  scrb_rom_model #(.WORD1(W1), .WORD2(W2), .WORD3(W3), .RESP_NS(40)) i_scrb_rom_model (
    .rom_cs(cs), .rom_sk(sclk), .rom_di(dout), .rom_do(rom_do), .write_count(wr_cnt));

  // -------------------------------
  // Clock, pulse counter, watchdog
  // -------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Counts self-test start pulses
  always @(posedge clk_sys) if (st_start === 1'b1) pulses++;
  initial begin
    repeat (80000) @(posedge clk_sys);
    err_count++;
    end_sim();
  end

  // -------------------------------
  // Bus tasks and helpers
  // -------------------------------
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_rd = 1'b0;
    rd_v = reg_rdata;
  endtask
  // Bounded wait for the ROM fetch to finish
  task automatic wait_fetch();
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK("fetch_started", 1'b1, busy)
    for (int k = 0; k < 20000 && busy !== 1'b0; k++) @(posedge clk_sys);
    #1;
    `CHK("fetch_busy", 1'b0, busy)
  endtask
  // Expected self-test word from the live inputs
  function automatic logic [15:0] st_word();
    return {3'h0, txd, txf, txc, 3'h0, rxd, rxf, rxc};
  endfunction
  task automatic end_sim();
    if (err_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // -------------------------------
  // Test sequence
  // -------------------------------
  initial begin
    {reg_wr, reg_rd, din_tb, sw_mode, txd, txf, rxd, rxf} = 8'h00;
    {reg_addr, reg_wdata, txc, rxc} = '0;
    err_count = 0;
    tests_run = 0;
    pulses = 0;
    strap = 1'b1;
    seed_v = $urandom(32'hd1fb8575);
    rst = 1'b1;
    repeat (12) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    // Fetch after reset lands words in low, middle, high
    wait_fetch();
    `CHK("selftest_pulses", 1, pulses)
    rd(8'h10); `CHK("addr_low", W1, rd_v)
    rd(8'h12); `CHK("addr_mid", W2, rd_v)
    rd(8'h14); `CHK("addr_high", W3, rd_v)
    `CHK("station_address", {W3, W2, W1}, sta)
    // Address writes stay in the registers only
    for (i = 0; i < 3; i++) begin
      v = 16'($urandom());
      wr(8'h10 + 8'(2 * i), v);
      rd(8'h10 + 8'(2 * i)); `CHK("addr_rw", v, rd_v)
      `CHK("station_slice", v, sta[16*i +: 16])
    end
    `CHK("rom_writes", 8'h00, wr_cnt)
    // Bus control fields, divider codes 0 to 2
    for (i = 0; i < 3; i++) begin
      // Reserved bits carry their read-back value of zero
      v = {9'h000, 1'($urandom()), 3'h0, 1'b0, 2'(i)};
      wr(8'h20, v);
      rd(8'h20); `CHK("bus_ctrl", v & 16'h0047, rd_v)
      `CHK("drive_high", v[6], drv_hi)
      `CHK("clock_select", 1'b0, clk_sel)
      `CHK("divider", 2'(i), div)
    end
    // Software pin control and live data-in
    sw_mode = 1'b1;
    for (i = 0; i < 8; i++) begin
      din_tb = 1'($urandom());
      wr(8'h22, 16'h0010 | 16'(i));
      `CHK("rom_pins", 3'(i), {dout, sclk, cs})
      rd(8'h22); `CHK("rom_ctrl", {11'h000, 1'b1, din_tb, 3'(i)}, rd_v)
    end
    wr(8'h22, 16'h0007);
    `CHK("rom_pins_off", 3'h0, {dout, sclk, cs})
    rd(8'h22); `CHK("rom_ctrl_off", 16'h0007, rd_v & 16'hfff7)
    sw_mode = 1'b0;
    // Self-test report follows its inputs
    for (i = 0; i < 8; i++) begin
      {txd, txf, txc, rxd, rxf, rxc} = 10'($urandom());
      rd(8'h24); `CHK("selftest", st_word(), rd_v)
    end
    // Reserved offsets read zero and ignore writes
    v = sta[15:0];
    for (i = 0; i < 4; i++) begin
      rd(8'h16 + 8'(2 * i));
      wr(8'h16 + 8'(2 * i), rd_v | 16'hffff);
      rd(8'h16 + 8'(2 * i)); `CHK("reserved", 16'h0000, rd_v)
    end
    rd(8'h10); `CHK("addr_kept", v, rd_v)
    // Queue manager soft reset alone
    wr(8'h26, 16'h0002);
    `CHK("qm_reset", 2'b10, {qm_rst, chip_rst})
    rd(8'h26); `CHK("soft_rst", 16'h0002, rd_v)
    wr(8'h26, 16'h0000);
    `CHK("qm_released", 2'b00, {qm_rst, chip_rst})
    // Global soft reset clears the bank
    wr(8'h20, 16'h0041);
    wr(8'h26, 16'h0001);
    `CHK("chip_reset", 2'b11, {qm_rst, chip_rst})
    wr(8'h26, 16'h0000);
    @(posedge clk_sys);
    #1;
    `CHK("chip_released", 2'b00, {qm_rst, chip_rst})
    `CHK("selftest_again", 2, pulses)
    wait_fetch();
    rd(8'h20); `CHK("bus_default", 16'h0000, rd_v)
    `CHK("drive_default", 1'b0, drv_hi)
    `CHK("station_refetch", {W3, W2, W1}, sta)
    // Hard reset with no ROM fitted: no fetch, host loads the address
    strap = 1'b0;
    rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    `CHK("no_rom_idle", 1'b0, busy)
    `CHK("no_rom_addr", 48'h0, sta)
    `CHK("selftest_hard", 3, pulses)
    for (i = 0; i < 3; i++) begin
      wr(8'h10 + 8'(2 * i), W2 ^ 16'(i));
    end
    `CHK("host_address", {W2 ^ 16'h0002, W2 ^ 16'h0001, W2}, sta)
    end_sim();
  end
endmodule
